//--- hdl/prsf_pkg.sv
// package: command codes, bit positions and carriers for the rail status flags
package prsf_pkg;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
	localparam logic [7:0] CMD_INPUT_SUPPLY_STATUS   = 8'h7c;
	localparam logic [7:0] STATUS_RESET               = 8'h00;
	// output voltage status bits
	localparam int OV_FAULT_BIT   = 7;
	localparam int OV_WARN_BIT    = 6;
	localparam int UV_WARN_BIT    = 5;
	localparam int UV_FAULT_BIT   = 4;
	localparam int LIMIT_BIT      = 3;
	localparam int TIMEOUT_BIT    = 2;
	localparam logic [7:0] VOUT_SUPPORTED = 8'hfc;
	// output current status bits
	localparam int OC_FAULT_BIT   = 7;
	localparam int OC_WARN_BIT    = 5;
	localparam logic [7:0] IOUT_SUPPORTED = 8'ha0;
	// input supply status bits
	localparam int IN_OV_FAULT_BIT = 7;
	localparam int IN_UV_WARN_BIT  = 5;
	localparam int IN_LOW_BIT      = 3;
	localparam logic [7:0] INPUT_LATCHED  = 8'ha0;
	// summary bits of the status word
	localparam int SUM_VOUT_BIT = 15;
	localparam int SUM_IOUT_BIT = 14;
	localparam int SUM_INPUT_BIT = 13;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef struct packed {
		logic output_overvoltage_fault;
		logic output_overvoltage_warning;
		logic output_undervoltage_warning;
		logic output_undervoltage_fault;
		logic output_limit_clamped;
		logic startup_timeout;
		logic output_overcurrent_fault;
		logic output_overcurrent_warning;
		logic input_overvoltage_fault;
		logic input_undervoltage_warning;
		logic power_input_above_on;
		logic internal_5v_rail_ok;
	} prsf_events_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       clear_faults;
		logic [7:0] cmd;
		logic [7:0] data;
	} prsf_req_t;

	typedef struct packed {
		logic [7:0] vout;
		logic [7:0] iout;
		logic [7:0] input_supply;
	} prsf_masks_t;
endpackage : prsf_pkg

//--- hdl/prsf_sync.sv
// two-flop synchroniser for the condition inputs
`timescale 1ns/10ps
module prsf_sync #(
	parameter int W = 12
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			meta_reg <= '0;
			q_out    <= '0;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule : prsf_sync

//--- hdl/prsf_flag_byte.sv
// one latched status byte with write-one-to-clear and clear-all
`timescale 1ns/10ps
module prsf_flag_byte #(
	parameter logic [7:0] SUPPORTED = 8'hff
) (
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] set_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       clear_all_in,
	output logic      [7:0] flags_out
);
	logic [7:0] clr;

	always_comb begin
		clr = '0;
		if (clear_all_in)
			clr = 8'hff;
		else if (wr_in)
			clr = wdata_in;
	end

	// set wins over clear so a fault arriving during a clear is kept
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			flags_out <= prsf_pkg::STATUS_RESET;
		else
			flags_out <= ((flags_out & ~clr) | set_in) & SUPPORTED;
	end
endmodule : prsf_flag_byte

//--- hdl/prsf_status_top.sv
// rail status bytes: output voltage, output current, input supply and alert
// How it works
// - output overvoltage fault latches bit 7; each overvoltage kind has its own mask bit.
// - output overvoltage warning latches bit 6 until cleared.
// - undervoltage warning latches bit 5, undervoltage fault latches bit 4.
// - output limit clamping latches bit 3, startup timeout latches bit 2.
// - output status bits 1 and 0 always read zero.
// - clear-faults or writing one to a bit clears it; zeros untouched.
// - output status answers command 7a with one byte read or write.
// - current status at 7b; overcurrent fault bit 7, warning bit 5.
// - current status bit 6 and bits 4 to 0 read zero.
// - input status at 7c; input overvoltage fault latches bit 7.
// - input bits 6, 4 and 2 to 0 read zero.
// - input undervoltage warning latches bit 5 and may raise alert.
// - undervoltage warning masked until input first rises above turn-on.
// - bit 3 live: input below turn-on or 5 V rail low.
// - live input-low bit set out of reset, never raises alert.
// - each alerting bit has a mask bit; masked bits still latch.
// - status word bits 15, 14, 13 summarise voltage, current, input.
`timescale 1ns/10ps
module prsf_status_top (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	input  wire prsf_pkg::prsf_events_t events_in,
	input  wire prsf_pkg::prsf_req_t   req_in,
	input  wire prsf_pkg::prsf_masks_t masks_in,
	output logic [7:0]                 rdata_out,
	output logic                       rvalid_out,
	output logic [15:0]                status_word_out,
	output logic                       alert_n_out
);
	prsf_pkg::prsf_events_t ev;
	logic [7:0] vout_set;
	logic [7:0] iout_set;
	logic [7:0] in_set;
	logic [7:0] vout_flags;
	logic [7:0] iout_flags;
	logic [7:0] in_flags;
	logic [7:0] in_view;
	logic       seen_on_reg;
	logic       low_live;
	logic       wr_vout;
	logic       wr_iout;
	logic       wr_in;
	logic       alert_next;
	logic       alert_reg;

	// conditions come from analog comparators on another timebase
	prsf_sync #(.W($bits(prsf_pkg::prsf_events_t))) u_sync (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.d_in     (events_in),
		.q_out    (ev)
	);

	function automatic logic cmd_hit(input logic [7:0] c, input logic [7:0] code);
		return c == code;
	endfunction : cmd_hit

	assign wr_vout = req_in.wr && cmd_hit(req_in.cmd, prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS);
	assign wr_iout = req_in.wr && cmd_hit(req_in.cmd, prsf_pkg::CMD_OUTPUT_CURRENT_STATUS);
	assign wr_in   = req_in.wr && cmd_hit(req_in.cmd, prsf_pkg::CMD_INPUT_SUPPLY_STATUS);

	// undervoltage warning armed only after input has once been above turn-on
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			seen_on_reg <= 1'b0;
		else if (ev.power_input_above_on)
			seen_on_reg <= 1'b1;
	end

	// synced inputs reset low, so live bit reads 1 out of reset
	assign low_live = !ev.power_input_above_on || !ev.internal_5v_rail_ok;

	always_comb begin
		vout_set = '0;
		vout_set[prsf_pkg::OV_FAULT_BIT] = ev.output_overvoltage_fault;
		vout_set[prsf_pkg::OV_WARN_BIT]  = ev.output_overvoltage_warning;
		vout_set[prsf_pkg::UV_WARN_BIT]  = ev.output_undervoltage_warning;
		vout_set[prsf_pkg::UV_FAULT_BIT] = ev.output_undervoltage_fault;
		vout_set[prsf_pkg::LIMIT_BIT]    = ev.output_limit_clamped;
		vout_set[prsf_pkg::TIMEOUT_BIT]  = ev.startup_timeout;
		iout_set = '0;
		iout_set[prsf_pkg::OC_FAULT_BIT] = ev.output_overcurrent_fault;
		iout_set[prsf_pkg::OC_WARN_BIT]  = ev.output_overcurrent_warning;
		in_set = '0;
		in_set[prsf_pkg::IN_OV_FAULT_BIT] = ev.input_overvoltage_fault;
		in_set[prsf_pkg::IN_UV_WARN_BIT]  = ev.input_undervoltage_warning && seen_on_reg;
	end

	// unsupported bits forced to zero by the SUPPORTED mask
	prsf_flag_byte #(.SUPPORTED(prsf_pkg::VOUT_SUPPORTED)) u_vout (
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.set_in       (vout_set),
		.wr_in        (wr_vout),
		.wdata_in     (req_in.data),
		.clear_all_in (req_in.clear_faults),
		.flags_out    (vout_flags)
	);

	prsf_flag_byte #(.SUPPORTED(prsf_pkg::IOUT_SUPPORTED)) u_iout (
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.set_in       (iout_set),
		.wr_in        (wr_iout),
		.wdata_in     (req_in.data),
		.clear_all_in (req_in.clear_faults),
		.flags_out    (iout_flags)
	);

	prsf_flag_byte #(.SUPPORTED(prsf_pkg::INPUT_LATCHED)) u_in (
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.set_in       (in_set),
		.wr_in        (wr_in),
		.wdata_in     (req_in.data),
		.clear_all_in (req_in.clear_faults),
		.flags_out    (in_flags)
	);

	always_comb begin
		in_view = in_flags;
		in_view[prsf_pkg::IN_LOW_BIT] = low_live;
	end

	// reads are side-effect free; unknown codes answer zero
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rdata_out  <= prsf_pkg::STATUS_RESET;
			rvalid_out <= 1'b0;
		end else begin
			rvalid_out <= req_in.rd;
			if (req_in.rd) begin
				case (req_in.cmd)
					prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS: rdata_out <= vout_flags;
					prsf_pkg::CMD_OUTPUT_CURRENT_STATUS: rdata_out <= iout_flags;
					prsf_pkg::CMD_INPUT_SUPPLY_STATUS:   rdata_out <= in_view;
					default:                             rdata_out <= prsf_pkg::STATUS_RESET;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			status_word_out <= prsf_pkg::WORD_RESET;
		else begin
			status_word_out <= prsf_pkg::WORD_RESET;
			status_word_out[prsf_pkg::SUM_VOUT_BIT]  <= |vout_flags;
			status_word_out[prsf_pkg::SUM_IOUT_BIT]  <= |iout_flags;
			status_word_out[prsf_pkg::SUM_INPUT_BIT] <= |in_flags;
		end
	end

	// mask bit 1 blocks that flag; live bit excluded since in_flags lacks it
	assign alert_next = |(vout_flags & ~masks_in.vout)
		| |(iout_flags & ~masks_in.iout)
		| |(in_flags & ~masks_in.input_supply);

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			alert_reg <= 1'b0;
		else
			alert_reg <= alert_next;
	end

	assign alert_n_out = !alert_reg;

	sequence s_read_vout;
		req_in.rd && req_in.cmd == prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS;
	endsequence : s_read_vout

	sequence s_read_iout;
		req_in.rd && req_in.cmd == prsf_pkg::CMD_OUTPUT_CURRENT_STATUS;
	endsequence : s_read_iout

	sequence s_read_input;
		req_in.rd && req_in.cmd == prsf_pkg::CMD_INPUT_SUPPLY_STATUS;
	endsequence : s_read_input

	// a raw condition held for three edges must cross the synchroniser and land
	sequence s_pin_ov;
		events_in.output_overvoltage_fault [*3];
	endsequence : s_pin_ov

	sequence s_pin_oc;
		events_in.output_overcurrent_fault [*3];
	endsequence : s_pin_oc

	sequence s_pin_in_ov;
		events_in.input_overvoltage_fault [*3];
	endsequence : s_pin_in_ov

	a_vout_fault_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_overvoltage_fault |=> vout_flags[prsf_pkg::OV_FAULT_BIT])
		else $error("overvoltage fault not latched");
	a_ov_pin_path: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_pin_ov |=> vout_flags[prsf_pkg::OV_FAULT_BIT])
		else $error("overvoltage fault lost on its way in");
	a_warn_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		vout_flags[prsf_pkg::OV_WARN_BIT] && !req_in.clear_faults && !wr_vout
		|=> vout_flags[prsf_pkg::OV_WARN_BIT])
		else $error("overvoltage warning dropped");
	a_ov_warn_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_overvoltage_warning |=> vout_flags[prsf_pkg::OV_WARN_BIT])
		else $error("overvoltage warning not latched");
	a_uv_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_undervoltage_fault && ev.output_undervoltage_warning
		|=> vout_flags[prsf_pkg::UV_FAULT_BIT] && vout_flags[prsf_pkg::UV_WARN_BIT])
		else $error("undervoltage not latched");
	a_limit_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_limit_clamped || ev.startup_timeout
		|=> vout_flags[prsf_pkg::LIMIT_BIT] || vout_flags[prsf_pkg::TIMEOUT_BIT])
		else $error("limit or timeout not latched");
	a_clamp_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_limit_clamped |=> vout_flags[prsf_pkg::LIMIT_BIT])
		else $error("limit clamp not latched");
	a_timeout_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.startup_timeout |=> vout_flags[prsf_pkg::TIMEOUT_BIT])
		else $error("startup timeout not latched");
	a_zero_bits: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		vout_flags[1:0] == 2'h0 && (iout_flags & ~prsf_pkg::IOUT_SUPPORTED) == 8'h00
		&& (in_flags & ~prsf_pkg::INPUT_LATCHED) == 8'h00)
		else $error("unsupported bit set");

	a_clear_all: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		req_in.clear_faults && !ev.output_overcurrent_fault && !ev.output_overcurrent_warning
		|=> iout_flags == 8'h00)
		else $error("clear faults missed");
	a_clear_vout: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		req_in.clear_faults && vout_set == 8'h00 |=> vout_flags == 8'h00)
		else $error("clear faults missed on output voltage byte");
	a_clear_input: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		req_in.clear_faults && in_set == 8'h00 |=> in_flags == 8'h00)
		else $error("clear faults missed on input byte");
	a_w1c_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		wr_vout && req_in.data[prsf_pkg::OV_FAULT_BIT] && !ev.output_overvoltage_fault
		|=> !vout_flags[prsf_pkg::OV_FAULT_BIT])
		else $error("write one did not clear");
	a_w0_keeps: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		wr_vout && !req_in.data[prsf_pkg::OV_FAULT_BIT] && !req_in.clear_faults
		&& vout_flags[prsf_pkg::OV_FAULT_BIT] |=> vout_flags[prsf_pkg::OV_FAULT_BIT])
		else $error("write zero cleared a flag");

	a_oc_fault_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_overcurrent_fault |=> iout_flags[prsf_pkg::OC_FAULT_BIT])
		else $error("overcurrent fault not latched");
	a_oc_warn_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.output_overcurrent_warning |=> iout_flags[prsf_pkg::OC_WARN_BIT])
		else $error("overcurrent warning not latched");
	a_oc_pin_path: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_pin_oc |=> iout_flags[prsf_pkg::OC_FAULT_BIT])
		else $error("overcurrent fault lost on its way in");
	a_in_ov_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.input_overvoltage_fault |=> in_flags[prsf_pkg::IN_OV_FAULT_BIT])
		else $error("input overvoltage not latched");
	a_in_ov_path: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_pin_in_ov |=> in_flags[prsf_pkg::IN_OV_FAULT_BIT])
		else $error("input overvoltage lost on its way in");
	a_in_uvw_latch: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.input_undervoltage_warning && seen_on_reg |=> in_flags[prsf_pkg::IN_UV_WARN_BIT])
		else $error("input undervoltage warning not latched");

	a_uvw_gated: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!seen_on_reg && !$past(in_flags[prsf_pkg::IN_UV_WARN_BIT])
		|-> !in_flags[prsf_pkg::IN_UV_WARN_BIT])
		else $error("uv warning set before turn-on");
	a_seen_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		seen_on_reg |=> seen_on_reg)
		else $error("turn-on arming lost");
	a_seen_arms: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ev.power_input_above_on |=> seen_on_reg)
		else $error("turn-on arming missed");
	a_live_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		in_view[prsf_pkg::IN_LOW_BIT] == low_live)
		else $error("live low bit wrong");
	a_live_no_alert: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		low_live && !alert_next |=> alert_n_out)
		else $error("live low bit raised alert");
	a_reset_state: assert property (@(posedge mclk_in)
		!rst_n_in |=> !rvalid_out && alert_n_out && status_word_out == 16'h0000
		&& in_view[prsf_pkg::IN_LOW_BIT])
		else $error("outputs wrong after reset");

	a_rvalid_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		req_in.rd |=> rvalid_out)
		else $error("read not answered");
	a_rvalid_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!req_in.rd |=> !rvalid_out)
		else $error("read valid without read");
	a_read_vout: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_read_vout |=> rdata_out == $past(vout_flags))
		else $error("output voltage byte read wrong");
	a_read_iout: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_read_iout |=> rdata_out == $past(iout_flags))
		else $error("output current byte read wrong");
	a_read_input: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_read_input |=> rdata_out == $past(in_view))
		else $error("input byte read wrong");
	a_read_other: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		req_in.rd && !cmd_hit(req_in.cmd, prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS)
		&& !cmd_hit(req_in.cmd, prsf_pkg::CMD_OUTPUT_CURRENT_STATUS)
		&& !cmd_hit(req_in.cmd, prsf_pkg::CMD_INPUT_SUPPLY_STATUS) |=> rdata_out == 8'h00)
		else $error("unknown command read not zero");
	a_read_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		req_in.rd && !wr_vout && !req_in.clear_faults && vout_set == 8'h00
		|=> $stable(vout_flags))
		else $error("read disturbed the flags");

	a_word_vout: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		1'b1 |=> status_word_out[prsf_pkg::SUM_VOUT_BIT] == $past(|vout_flags))
		else $error("voltage summary bit wrong");
	a_word_iout: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		1'b1 |=> status_word_out[prsf_pkg::SUM_IOUT_BIT] == $past(|iout_flags))
		else $error("current summary bit wrong");
	a_word_input: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		1'b1 |=> status_word_out[prsf_pkg::SUM_INPUT_BIT] == $past(|in_flags))
		else $error("input summary bit wrong");
	a_word_rest: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		status_word_out[prsf_pkg::SUM_INPUT_BIT-1:0] == '0)
		else $error("status word low bits not zero");

	a_alert_follows: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(alert_next) |=> ##[0:1] !alert_n_out)
		else $error("alert not raised");
	a_alert_track: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		1'b1 |=> alert_n_out == !$past(alert_next))
		else $error("alert does not follow the flags");
	a_alert_masked: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		&masks_in |=> alert_n_out)
		else $error("masked flag raised alert");
endmodule : prsf_status_top

//--- bench/prsf_host_model.sv
// host model: issues status reads, writes and clear-all requests
`timescale 1ns/10ps
module prsf_host_model (
	input  wire logic           mclk_in,
	input  wire logic [7:0]     rdata_in,
	input  wire logic           rvalid_in,
	output prsf_pkg::prsf_req_t req_out
);
	initial req_out = '0;

	// one request per call, held for exactly one taking edge
	task automatic xfer(input logic w, input logic r, input logic c, input logic [7:0] cmd,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		@(posedge mclk_in);
		#1;
		req_out = '{wr: w, rd: r, clear_faults: c, cmd: cmd, data: d};
		@(posedge mclk_in);
		#1;
		// released lines show garbage, never the last value
		req_out = '{wr: 1'b0, rd: 1'b0, clear_faults: 1'b0, cmd: ~cmd, data: ~d};
		q = rdata_in;
		ok = rvalid_in;
	endtask : xfer
endmodule : prsf_host_model

//--- bench/pmbus_rail_status_flags_test.sv
// self-checking bench for the rail status flags
`timescale 1ns/10ps
module pmbus_rail_status_flags_test;
	logic                   mclk_in;
	logic                   rst_n_in;
	prsf_pkg::prsf_events_t ev;
	prsf_pkg::prsf_masks_t  mk;
	prsf_pkg::prsf_req_t    req;
	logic [7:0]             rdata;
	logic                   rvalid;
	logic [15:0]            word;
	logic                   alert_n;
	int                     failures;
	int                     compares;
	int                     cycles;

	prsf_status_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .events_in(ev), .req_in(req),
		.masks_in(mk), .rdata_out(rdata), .rvalid_out(rvalid), .status_word_out(word),
		.alert_n_out(alert_n));
	prsf_host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid),
		.req_out(req));

	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	task automatic final_report();
		if (failures == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// whole run is about 130 cycles; the guard stops it at 3000
	initial cycles = 0;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] q;
		logic       ok;
		host.xfer(1'b0, 1'b1, 1'b0, cmd, 8'h00, q, ok);
		check("rvalid", 16'h0001, {15'h0000, ok});
		check("rdata", {8'h00, exp}, {8'h00, q});
	endtask : rd

	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		logic [7:0] q;
		logic       ok;
		host.xfer(1'b1, 1'b0, 1'b0, cmd, d, q, ok);
	endtask : wr

	task automatic clr();
		logic [7:0] q;
		logic       ok;
		host.xfer(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, q, ok);
	endtask : clr

	// condition held long enough to cross the two-flop synchroniser
	task automatic pulse(input logic [11:0] e);
		@(posedge mclk_in);
		#1;
		ev = prsf_pkg::prsf_events_t'(ev | e);
		repeat (3) @(posedge mclk_in);
		#1;
		ev = prsf_pkg::prsf_events_t'(ev & ~e);
		repeat (5) @(posedge mclk_in);
		#1;
	endtask : pulse

	task automatic t_power();
		rd(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'h08);
		check("alert_n", 16'h0001, {15'h0000, alert_n});
		check("word", 16'h0000, word);
		pulse(12'h004);
		rd(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'h08);
		check("alert_n", 16'h0001, {15'h0000, alert_n});
		ev = prsf_pkg::prsf_events_t'(12'h003);
		repeat (4) @(posedge mclk_in);
		rd(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'h00);
	endtask : t_power

	task automatic t_vout();
		pulse(12'hfc0);
		rd(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'hfc);
		check("word", 16'h8000, word);
		check("alert_n", 16'h0000, {15'h0000, alert_n});
		wr(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'h83);
		wr(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'h00);
		rd(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'h7c);
		clr();
		rd(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'h00);
		check("alert_n", 16'h0001, {15'h0000, alert_n});
	endtask : t_vout

	task automatic t_iout();
		pulse(12'h030);
		rd(prsf_pkg::CMD_OUTPUT_CURRENT_STATUS, 8'ha0);
		check("word", 16'h4000, word);
		wr(prsf_pkg::CMD_OUTPUT_CURRENT_STATUS, 8'h5f);
		rd(prsf_pkg::CMD_OUTPUT_CURRENT_STATUS, 8'ha0);
		wr(prsf_pkg::CMD_OUTPUT_CURRENT_STATUS, 8'h20);
		rd(prsf_pkg::CMD_OUTPUT_CURRENT_STATUS, 8'h80);
		clr();
		rd(prsf_pkg::CMD_OUTPUT_CURRENT_STATUS, 8'h00);
	endtask : t_iout

	task automatic t_input();
		pulse(12'h00c);
		rd(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'ha0);
		check("word", 16'h2000, word);
		check("alert_n", 16'h0000, {15'h0000, alert_n});
		wr(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'h5f);
		rd(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'ha0);
		wr(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'ha0);
		rd(prsf_pkg::CMD_INPUT_SUPPLY_STATUS, 8'h00);
		check("alert_n", 16'h0001, {15'h0000, alert_n});
	endtask : t_input

	task automatic t_mask();
		mk = '{vout: 8'hff, iout: 8'hff, input_supply: 8'hff};
		pulse(12'hffc);
		check("alert_n", 16'h0001, {15'h0000, alert_n});
		rd(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'hfc);
		rd(8'h79, 8'h00);
		clr();
		mk.vout = 8'hfb;
		pulse(12'h040);
		check("alert_n", 16'h0000, {15'h0000, alert_n});
		clr();
	endtask : t_mask

	// mid-run reset: latched flags and outputs come back to their idle state
	task automatic t_reset();
		mk = '0;
		pulse(12'h800);
		check("word", 16'h8000, word);
		rst_n_in = 1'b0;
		repeat (3) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		check("word", 16'h0000, word);
		check("alert_n", 16'h0001, {15'h0000, alert_n});
		check("rdata", 16'h0000, {8'h00, rdata});
		rd(prsf_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 8'h00);
	endtask : t_reset

	initial begin
		failures = 0;
		compares = 0;
		ev = '0;
		mk = '0;
		rst_n_in = 1'b0;
		repeat (8) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		t_power();
		t_vout();
		t_iout();
		t_input();
		t_mask();
		t_reset();
		final_report();
	end
endmodule : pmbus_rail_status_flags_test
